//--- hw/srit_fill_timer.sv
module srit_fill_timer
  import srit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wait_en,
  input  wire logic [15:0] fill_cfg,
  input  wire logic [15:0] bit_clks,
  input  wire logic [3:0]  frame_bits,
  input  wire logic        cksum_sent,
  input  wire logic        ack_rx,
  output logic             pad_pulse,
  output logic             enq_pulse,
  output logic             waiting,
  output logic [15:0]      delay_stat
);

  typedef enum logic {FT_IDLE, FT_WAIT} srit_ft_state_type;

  srit_ft_state_type state_ff;
  srit_ft_state_type nxt_state;
  logic [15:0]       bit_cnt_ff;
  logic [15:0]       nxt_bit_cnt;
  logic [3:0]        bitn_ff;
  logic [3:0]        nxt_bitn;
  logic [15:0]       pad_cnt_ff;
  logic [15:0]       nxt_pad_cnt;
  logic [15:0]       stat_ff;
  logic [15:0]       nxt_stat;
  logic              pad_ff;
  logic              nxt_pad;
  logic              enq_ff;
  logic              nxt_enq;

  // ==========================================================================
  // Character period and fill count decode
  wire [15:0] eff_fill  = (fill_cfg < FILL_MIN) ? FILL_MIN : fill_cfg;
  wire [16:0] bit_next  = {1'b0, bit_cnt_ff} + {1'b0, ONE16};
  wire        bit_done  = bit_next >= {1'b0, bit_clks};
  wire [4:0]  bitn_next = {1'b0, bitn_ff} + 5'h01;
  wire        char_done = bit_done && (bitn_next >= {1'b0, frame_bits});
  wire [15:0] pad_next  = pad_cnt_ff + ONE16;
  wire        last_pad  = char_done && (pad_next >= eff_fill);

  // ==========================================================================
  // Wait sequence
  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_bitn    = bitn_ff;
    nxt_pad_cnt = pad_cnt_ff;
    nxt_stat    = stat_ff;
    nxt_pad     = 1'b0;
    nxt_enq     = 1'b0;
    if (cksum_sent && wait_en) begin
      nxt_state   = FT_WAIT;
      nxt_bit_cnt = ZERO16;
      nxt_bitn    = 4'h0;
      nxt_pad_cnt = ZERO16;
    end else begin
      unique case (state_ff)
        FT_IDLE: begin
          nxt_state = FT_IDLE;
        end
        FT_WAIT: begin
          if (!wait_en) begin
            nxt_state = FT_IDLE;
          end else if (ack_rx) begin
            nxt_stat  = pad_cnt_ff;
            nxt_state = FT_IDLE;
          end else begin
            nxt_bit_cnt = bit_done ? ZERO16 : bit_next[15:0];
            nxt_bitn    = char_done ? 4'h0 : (bit_done ? bitn_next[3:0] : bitn_ff);
            if (char_done) begin
              nxt_pad     = 1'b1;
              nxt_pad_cnt = pad_next;
            end
            if (last_pad) begin
              nxt_enq   = 1'b1;
              nxt_state = FT_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff   <= FT_IDLE;
      bit_cnt_ff <= ZERO16;
      bitn_ff    <= 4'h0;
      pad_cnt_ff <= ZERO16;
      stat_ff    <= ZERO16;
      pad_ff     <= 1'b0;
      enq_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      bitn_ff    <= nxt_bitn;
      pad_cnt_ff <= nxt_pad_cnt;
      stat_ff    <= nxt_stat;
      pad_ff     <= nxt_pad;
      enq_ff     <= nxt_enq;
    end
  end

  assign pad_pulse  = pad_ff;
  assign enq_pulse  = enq_ff;
  assign waiting    = (state_ff == FT_WAIT);
  assign delay_stat = stat_ff;

endmodule

//--- hw/srit_pkg.sv
package srit_pkg;

  // ==========================================================================
  // Register numbers
  localparam logic [15:0] REG_P1_DELAY_STAT = 16'h0818;
  localparam logic [15:0] REG_P2_DELAY_STAT = 16'h0838;
  localparam logic [15:0] REG_P1_FILL_COUNT = 16'h1F80;
  localparam logic [15:0] REG_P2_FILL_COUNT = 16'h1FA0;

  // ==========================================================================
  // Reset values and limits
  localparam logic [15:0] FILL_MIN      = 16'h000A;
  localparam logic [15:0] FILL_RST      = 16'h000A;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [15:0] ONE16         = 16'h0001;
  localparam logic [3:0]  ROUTE_MAX     = 4'h8;
  localparam logic [3:0]  ROUTE_MIN_NET = 4'h2;
  localparam int          DROP_W        = 8;
  localparam int          ROUTE_SLOTS   = 8;
  localparam logic [3:0]  BITS_ASCII    = 4'h7;
  localparam logic [3:0]  BITS_RTU      = 4'h8;

  // ==========================================================================
  // Port modes and port indices
  typedef enum logic [2:0] {
    PM_PEER,
    PM_NETWORK_LINK,
    PM_POWER_METER,
    PM_MODBUS_MASTER,
    PM_MODBUS_SLAVE,
    PM_OTHER
  } srit_mode_type;

  localparam logic [1:0] PORT_ETH = 2'h0;
  localparam logic [1:0] PORT_P1  = 2'h1;
  localparam logic [1:0] PORT_P2  = 2'h2;

endpackage

//--- hw/srit_route_decode.sv
module srit_route_decode
  import srit_pkg::*;
(
  input  wire logic [3:0]                    route_len,
  input  wire logic [DROP_W*ROUTE_SLOTS-1:0] route_drops,
  input  wire logic [1:0]                    arrive_port,
  input  wire logic [DROP_W-1:0]             eth_drop,
  input  wire logic [DROP_W-1:0]             p1_drop,
  input  wire logic [DROP_W-1:0]             p2_drop,
  output logic                               is_local,
  output logic                               exit_valid,
  output logic [1:0]                         exit_port,
  output logic                               route_error,
  output logic                               drop_conflict
);

  logic [DROP_W-1:0] arrive_drop;
  logic [DROP_W-1:0] next_drop;
  logic [3:0]        hit_idx;
  logic              hit;

  // ==========================================================================
  // Locate the arrival port's drop in the route
  assign arrive_drop = (arrive_port == PORT_P1) ? p1_drop :
                       (arrive_port == PORT_P2) ? p2_drop : eth_drop;

  always_comb begin
    hit       = 1'b0;
    hit_idx   = 4'h0;
    next_drop = '0;
    for (int i = 0; i < ROUTE_SLOTS; i++) begin
      if (!hit && (4'(i) < route_len) &&
          (route_drops[i*DROP_W +: DROP_W] == arrive_drop)) begin
        hit     = 1'b1;
        hit_idx = 4'(i);
        if (i < ROUTE_SLOTS - 1) begin
          next_drop = route_drops[(i+1)*DROP_W +: DROP_W];
        end
      end
    end
  end

  // ==========================================================================
  // Route decisions
  wire len_zero  = (route_len == 4'h0);
  wire len_bad   = (route_len > ROUTE_MAX) ||
                   (!len_zero && (route_len < ROUTE_MIN_NET));
  wire terminal  = hit && ((hit_idx + 4'h1) == route_len);
  wire to_eth    = (next_drop == eth_drop) && (arrive_port != PORT_ETH);
  wire to_p1     = (next_drop == p1_drop) && (arrive_port != PORT_P1);
  wire to_p2     = (next_drop == p2_drop) && (arrive_port != PORT_P2);
  wire crossing  = hit && !terminal && (to_eth || to_p1 || to_p2);

  assign drop_conflict = (eth_drop == p1_drop) || (eth_drop == p2_drop) ||
                         (p1_drop == p2_drop);
  assign is_local      = !len_bad && (len_zero || terminal);
  assign exit_valid    = !len_bad && crossing;
  assign exit_port     = to_eth ? PORT_ETH : (to_p1 ? PORT_P1 : PORT_P2);
  assign route_error   = len_bad || drop_conflict || (!len_zero && !terminal && !crossing);

endmodule

//--- hw/srit_top.sv
module srit_top
  import srit_pkg::*;
(
  input  wire logic                               CLK_SYS,
  input  wire logic                               SYS_RST,
  input  wire logic                               REG_WR,
  input  wire logic                               REG_RD,
  input  wire logic [15:0]                        REG_NUM,
  input  wire logic [15:0]                        REG_WDATA,
  output logic [15:0]                             REG_RDATA,
  output logic                                    REG_ACK,
  input  wire logic [2:0]                         P1_MODE,
  input  wire logic [15:0]                        P1_BIT_CLKS,
  input  wire logic [3:0]                         P1_FRAME_BITS,
  input  wire logic                               P1_CKSUM_SENT,
  input  wire logic                               P1_ACK_RX,
  output logic                                    P1_PAD_SEND,
  output logic                                    P1_ENQ_SEND,
  output logic                                    P1_WAITING,
  input  wire logic                               P1_MB_RTU,
  input  wire logic [7:0]                         P1_MB_ADDR,
  input  wire logic                               P1_RX_FRAME_END,
  input  wire logic [7:0]                         P1_RX_FRAME_ADDR,
  input  wire logic                               P1_TX_DONE,
  output logic                                    P1_TX_PERMIT,
  output logic [3:0]                              P1_DATA_BITS,
  input  wire logic [2:0]                         P2_MODE,
  input  wire logic [15:0]                        P2_BIT_CLKS,
  input  wire logic [3:0]                         P2_FRAME_BITS,
  input  wire logic                               P2_CKSUM_SENT,
  input  wire logic                               P2_ACK_RX,
  output logic                                    P2_PAD_SEND,
  output logic                                    P2_ENQ_SEND,
  output logic                                    P2_WAITING,
  input  wire logic                               P2_MB_RTU,
  input  wire logic [7:0]                         P2_MB_ADDR,
  input  wire logic                               P2_RX_FRAME_END,
  input  wire logic [7:0]                         P2_RX_FRAME_ADDR,
  input  wire logic                               P2_TX_DONE,
  output logic                                    P2_TX_PERMIT,
  output logic [3:0]                              P2_DATA_BITS,
  input  wire logic [DROP_W-1:0]                  ETH_DROP,
  input  wire logic [DROP_W-1:0]                  P1_DROP,
  input  wire logic [DROP_W-1:0]                  P2_DROP,
  input  wire logic                               RT_VALID,
  input  wire logic [3:0]                         RT_LEN,
  input  wire logic [DROP_W*ROUTE_SLOTS-1:0]      RT_DROPS,
  input  wire logic [1:0]                         RT_ARRIVE_PORT,
  output logic                                    RT_DONE,
  output logic                                    RT_LOCAL,
  output logic                                    RT_EXIT_VALID,
  output logic [1:0]                              RT_EXIT_PORT,
  output logic                                    RT_ERROR,
  output logic                                    DROP_CONFLICT
);

  logic [15:0] p1_fill_ff;
  logic [15:0] nxt_p1_fill;
  logic [15:0] p2_fill_ff;
  logic [15:0] nxt_p2_fill;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        ack_ff;
  logic [15:0] p1_stat;
  logic [15:0] p2_stat;
  logic        p1_grant_ff;
  logic        nxt_p1_grant;
  logic        p2_grant_ff;
  logic        nxt_p2_grant;
  logic        rt_done_ff;
  logic        rt_local_ff;
  logic        rt_exit_ff;
  logic [1:0]  rt_port_ff;
  logic        rt_err_ff;
  logic        rt_local;
  logic        rt_exit;
  logic [1:0]  rt_port;
  logic        rt_err;
  logic        conflict;

  // ==========================================================================
  // Register decode
  wire sel_p1_fill = (REG_NUM == REG_P1_FILL_COUNT);
  wire sel_p2_fill = (REG_NUM == REG_P2_FILL_COUNT);
  wire sel_p1_stat = (REG_NUM == REG_P1_DELAY_STAT);
  wire sel_p2_stat = (REG_NUM == REG_P2_DELAY_STAT);

  assign nxt_p1_fill = (REG_WR && sel_p1_fill) ? REG_WDATA : p1_fill_ff;
  assign nxt_p2_fill = (REG_WR && sel_p2_fill) ? REG_WDATA : p2_fill_ff;
  assign nxt_rdata   = !REG_RD     ? rdata_ff   :
                       sel_p1_fill ? p1_fill_ff :
                       sel_p2_fill ? p2_fill_ff :
                       sel_p1_stat ? p1_stat    :
                       sel_p2_stat ? p2_stat    : ZERO16;

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      p1_fill_ff <= FILL_RST;
      p2_fill_ff <= FILL_RST;
      rdata_ff   <= ZERO16;
      ack_ff     <= 1'b0;
    end else begin
      p1_fill_ff <= nxt_p1_fill;
      p2_fill_ff <= nxt_p2_fill;
      rdata_ff   <= nxt_rdata;
      ack_ff     <= REG_WR || REG_RD;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign REG_ACK   = ack_ff;

  // ==========================================================================
  // Fill character timers
  wire p1_pad_mode = (P1_MODE == PM_PEER) || (P1_MODE == PM_NETWORK_LINK) ||
                     (P1_MODE == PM_POWER_METER);
  wire p2_pad_mode = (P2_MODE == PM_PEER) || (P2_MODE == PM_NETWORK_LINK) ||
                     (P2_MODE == PM_POWER_METER);

  srit_fill_timer u_p1_timer (
    .clk        (CLK_SYS),
    .rst        (SYS_RST),
    .wait_en    (p1_pad_mode),
    .fill_cfg   (p1_fill_ff),
    .bit_clks   (P1_BIT_CLKS),
    .frame_bits (P1_FRAME_BITS),
    .cksum_sent (P1_CKSUM_SENT),
    .ack_rx     (P1_ACK_RX),
    .pad_pulse  (P1_PAD_SEND),
    .enq_pulse  (P1_ENQ_SEND),
    .waiting    (P1_WAITING),
    .delay_stat (p1_stat)
  );

  srit_fill_timer u_p2_timer (
    .clk        (CLK_SYS),
    .rst        (SYS_RST),
    .wait_en    (p2_pad_mode),
    .fill_cfg   (p2_fill_ff),
    .bit_clks   (P2_BIT_CLKS),
    .frame_bits (P2_FRAME_BITS),
    .cksum_sent (P2_CKSUM_SENT),
    .ack_rx     (P2_ACK_RX),
    .pad_pulse  (P2_PAD_SEND),
    .enq_pulse  (P2_ENQ_SEND),
    .waiting    (P2_WAITING),
    .delay_stat (p2_stat)
  );

  // ==========================================================================
  // Master and slave transmit permission
  wire p1_slave = (P1_MODE == PM_MODBUS_SLAVE);
  wire p2_slave = (P2_MODE == PM_MODBUS_SLAVE);
  wire p1_hit   = P1_RX_FRAME_END && (P1_RX_FRAME_ADDR == P1_MB_ADDR);
  wire p2_hit   = P2_RX_FRAME_END && (P2_RX_FRAME_ADDR == P2_MB_ADDR);

  assign nxt_p1_grant = p1_slave && (p1_hit || (p1_grant_ff && !P1_TX_DONE));
  assign nxt_p2_grant = p2_slave && (p2_hit || (p2_grant_ff && !P2_TX_DONE));

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      p1_grant_ff <= 1'b0;
      p2_grant_ff <= 1'b0;
    end else begin
      p1_grant_ff <= nxt_p1_grant;
      p2_grant_ff <= nxt_p2_grant;
    end
  end

  assign P1_TX_PERMIT = p1_slave ? p1_grant_ff : 1'b1;
  assign P2_TX_PERMIT = p2_slave ? p2_grant_ff : 1'b1;
  assign P1_DATA_BITS = P1_MB_RTU ? BITS_RTU : BITS_ASCII;
  assign P2_DATA_BITS = P2_MB_RTU ? BITS_RTU : BITS_ASCII;

  // ==========================================================================
  // Route steering
  srit_route_decode u_route (
    .route_len     (RT_LEN),
    .route_drops   (RT_DROPS),
    .arrive_port   (RT_ARRIVE_PORT),
    .eth_drop      (ETH_DROP),
    .p1_drop       (P1_DROP),
    .p2_drop       (P2_DROP),
    .is_local      (rt_local),
    .exit_valid    (rt_exit),
    .exit_port     (rt_port),
    .route_error   (rt_err),
    .drop_conflict (conflict)
  );

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      rt_done_ff  <= 1'b0;
      rt_local_ff <= 1'b0;
      rt_exit_ff  <= 1'b0;
      rt_port_ff  <= PORT_ETH;
      rt_err_ff   <= 1'b0;
    end else begin
      rt_done_ff <= RT_VALID;
      if (RT_VALID) begin
        rt_local_ff <= rt_local;
        rt_exit_ff  <= rt_exit;
        rt_port_ff  <= rt_port;
        rt_err_ff   <= rt_err;
      end
    end
  end

  assign RT_DONE       = rt_done_ff;
  assign RT_LOCAL      = rt_local_ff;
  assign RT_EXIT_VALID = rt_exit_ff;
  assign RT_EXIT_PORT  = rt_port_ff;
  assign RT_ERROR      = rt_err_ff;
  assign DROP_CONFLICT = conflict;

endmodule

//--- verification/srit_checker.sv
// ============================================================
// Port checker
module srit_checker
  import srit_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       SYS_RST,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic       REG_ACK,
  input wire logic [2:0] P1_MODE,
  input wire logic       P1_CKSUM_SENT,
  input wire logic       P1_PAD_SEND,
  input wire logic       P1_ENQ_SEND,
  input wire logic       P1_WAITING,
  input wire logic       P1_MB_RTU,
  input wire logic [3:0] P1_DATA_BITS,
  input wire logic [7:0] P1_MB_ADDR,
  input wire logic       P1_RX_FRAME_END,
  input wire logic [7:0] P1_RX_FRAME_ADDR,
  input wire logic       P1_TX_PERMIT,
  input wire logic       RT_VALID,
  input wire logic [3:0] RT_LEN,
  input wire logic       RT_DONE,
  input wire logic       RT_LOCAL,
  input wire logic       RT_EXIT_VALID,
  input wire logic       RT_ERROR,
  input wire logic [7:0] ETH_DROP,
  input wire logic [7:0] P1_DROP,
  input wire logic [7:0] P2_DROP,
  input wire logic       DROP_CONFLICT
);
  timeunit 1ns;
  timeprecision 1ns;

  wire logic addr_hit = P1_RX_FRAME_END && (P1_RX_FRAME_ADDR == P1_MB_ADDR);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  reg_ack_a: assert property ((REG_WR || REG_RD) |=> REG_ACK)
    else $error("register access not acknowledged");
  no_stray_ack_a: assert property (!(REG_WR || REG_RD) |=> !REG_ACK)
    else $error("acknowledge without access");
  wait_start_a: assert property (P1_CKSUM_SENT && P1_MODE <= 3'h2 |=> P1_WAITING)
    else $error("fill wait did not start");
  enq_last_pad_a: assert property (P1_ENQ_SEND |-> P1_PAD_SEND && !P1_WAITING)
    else $error("enquiry not with last fill character");
  mode_abort_a: assert property ((P1_MODE > 3'h2) [*2] |-> !P1_WAITING && !P1_PAD_SEND)
    else $error("fill wait active in other mode");
  permit_grant_a: assert property (P1_MODE == 3'h4 && addr_hit |=> P1_TX_PERMIT)
    else $error("slave not permitted after own frame");
  permit_cause_a: assert property (
    P1_MODE == 3'h4 && $past(P1_MODE) == 3'h4 && $rose(P1_TX_PERMIT) |-> $past(addr_hit))
    else $error("slave permitted without request");
  master_free_a: assert property (P1_MODE != 3'h4 |-> P1_TX_PERMIT)
    else $error("non slave mode blocked");
  data_bits_a: assert property (P1_DATA_BITS == (P1_MB_RTU ? BITS_RTU : BITS_ASCII))
    else $error("character width wrong");
  route_done_a: assert property (RT_VALID |=> RT_DONE)
    else $error("route result missing");
  route_len_a: assert property (
    RT_VALID && (RT_LEN == 4'h1 || RT_LEN > ROUTE_MAX) |=> RT_ERROR && !RT_EXIT_VALID)
    else $error("bad route length accepted");
  route_empty_a: assert property (RT_VALID && RT_LEN == 4'h0 |=> RT_LOCAL && !RT_EXIT_VALID)
    else $error("empty route not local");
  drop_unique_a: assert property (DROP_CONFLICT ==
    (ETH_DROP == P1_DROP || ETH_DROP == P2_DROP || P1_DROP == P2_DROP))
    else $error("drop conflict flag wrong");
  conflict_err_a: assert property (RT_VALID && DROP_CONFLICT |=> RT_ERROR)
    else $error("route taken with duplicate drops");
endmodule

bind srit_top srit_checker i_srit_checker (.*);

//--- verification/srit_peer.sv
// ============================================================
// Far side peer that answers after a set number of fill characters
module srit_peer
(
  input wire logic       clk,
  input wire logic       pad,
  input wire logic       enq,
  input wire logic [7:0] reply_pads,
  output logic           ack_rx
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] pads_seen;

  initial begin
    pads_seen = 8'h00;
    ack_rx = 1'b0;
  end

  // Turnaround is counted in fill characters; zero means no answer.
  always @(negedge clk) begin
    ack_rx <= 1'b0;
    if (enq || ack_rx) begin
      pads_seen <= 8'h00;
    end else if (pad) begin
      pads_seen <= pads_seen + 8'h01;
      if (reply_pads != 8'h00 && pads_seen + 8'h01 == reply_pads) ack_rx <= 1'b1;
    end
  end
endmodule

//--- verification/srit_top_bench.sv
// ============================================================
// Bench
module srit_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK_SYS, SYS_RST, REG_WR, REG_RD, REG_ACK, P1_CKSUM_SENT, P1_ACK_RX;
  logic        P1_MB_RTU, P1_RX_FRAME_END, P1_TX_DONE, RT_VALID, RT_DONE, RT_LOCAL;
  logic        P1_PAD_SEND, P1_ENQ_SEND, P1_WAITING, P1_TX_PERMIT, RT_EXIT_VALID;
  logic        P2_PAD_SEND, P2_ENQ_SEND, P2_WAITING, P2_TX_PERMIT, RT_ERROR, DROP_CONFLICT;
  logic [15:0] REG_NUM, REG_WDATA, REG_RDATA, P1_BIT_CLKS;
  logic [2:0]  P1_MODE;
  logic [3:0]  P1_FRAME_BITS, P1_DATA_BITS, P2_DATA_BITS, RT_LEN;
  logic [7:0]  P1_MB_ADDR, P1_RX_FRAME_ADDR, ETH_DROP, P1_DROP, P2_DROP, reply_pads;
  logic [63:0] RT_DROPS;
  logic [1:0]  RT_ARRIVE_PORT, RT_EXIT_PORT;
  int          n_fail, n_compared, m;

  srit_top i_srit_top (.*, .P2_MODE(P1_MODE), .P2_BIT_CLKS(P1_BIT_CLKS),
    .P2_FRAME_BITS(P1_FRAME_BITS), .P2_CKSUM_SENT(P1_CKSUM_SENT), .P2_ACK_RX(P1_ACK_RX),
    .P2_MB_RTU(P1_MB_RTU), .P2_MB_ADDR(P1_MB_ADDR), .P2_RX_FRAME_END(P1_RX_FRAME_END),
    .P2_RX_FRAME_ADDR(P1_RX_FRAME_ADDR), .P2_TX_DONE(P1_TX_DONE));

  srit_peer i_srit_peer (.clk(CLK_SYS), .pad(P1_PAD_SEND), .enq(P1_ENQ_SEND),
    .reply_pads(reply_pads), .ack_rx(P1_ACK_RX));

  always #5 CLK_SYS = ~CLK_SYS;

  // ============================================================
  // Shared tasks
  task step(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask

  task chk(input string nm, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task wrap_up;
    $display("Compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task give_up(input string nm);
    n_fail++;
    $display("Error %s expected end seen timeout", nm);
    wrap_up();
  endtask

  task wr(input logic [15:0] num, data);
    REG_NUM = num;
    REG_WDATA = data;
    REG_WR = 1'b1;
    step(1);
    chk("write ack", 1, REG_ACK);
    REG_WR = 1'b0;
    step(1);
  endtask

  task rd(input string nm, input logic [15:0] num, exp);
    REG_NUM = num;
    REG_RD = 1'b1;
    step(1);
    chk(nm, {1'b1, exp}, {REG_ACK, REG_RDATA});
    REG_RD = 1'b0;
    step(1);
  endtask

  task run_wait(input logic [2:0] md, input logic [15:0] e1, e2, input logic en);
    int i;
    logic [15:0] n1, n2, t1, t2;
    n1 = 16'h0000;
    n2 = 16'h0000;
    t1 = 16'h0000;
    t2 = 16'h0000;
    P1_MODE = md;
    P1_CKSUM_SENT = 1'b1;
    for (i = 0; i < 300; i++) begin
      step(1);
      P1_CKSUM_SENT = 1'b0;
      n1 = n1 + {15'h0000, P1_PAD_SEND};
      n2 = n2 + {15'h0000, P2_PAD_SEND};
      if (P1_ENQ_SEND === 1'b1) t1 = i[15:0];
      if (P2_ENQ_SEND === 1'b1) t2 = i[15:0];
      if (i > 1 && P1_WAITING === 1'b0 && P2_WAITING === 1'b0) break;
    end
    if (i == 300) give_up("fill wait");
    chk("pads p1", e1, n1);
    chk("pads p2", e2, n2);
    chk("enq cycle p1", en ? e1 * 16'h0006 : 16'h0000, t1);
    chk("enq cycle p2", en ? e2 * 16'h0006 : 16'h0000, t2);
  endtask

  task frame(input logic [7:0] addr);
    P1_RX_FRAME_ADDR = addr;
    P1_RX_FRAME_END = 1'b1;
    step(1);
    P1_RX_FRAME_END = 1'b0;
    step(1);
  endtask

  task rt(input logic [3:0] len, input logic [63:0] drops, input logic [1:0] arr,
          input logic [5:0] exp, input logic [5:0] mask = 6'h3F);
    RT_LEN = len;
    RT_DROPS = drops;
    RT_ARRIVE_PORT = arr;
    RT_VALID = 1'b1;
    step(1);
    chk("route result", exp, mask & {RT_DONE, RT_LOCAL, RT_EXIT_VALID, RT_ERROR,
        RT_EXIT_VALID ? RT_EXIT_PORT : 2'h0});
    RT_VALID = 1'b0;
    step(1);
  endtask

  // ============================================================
  // Scenarios
  task t_regs;
    rd("fill p1 reset", 16'h1F80, 16'h000A);
    rd("fill p2 reset", 16'h1FA0, 16'h000A);
    rd("stat p1 reset", 16'h0818, 16'h0000);
    wr(16'h0838, 16'h1234);
    rd("stat p2 read only", 16'h0838, 16'h0000);
    rd("unmapped", 16'h0100, 16'h0000);
    wr(16'h1F80, 16'h0003);
    wr(16'h1FA0, 16'h0014);
    rd("fill p1", 16'h1F80, 16'h0003);
    rd("fill p2", 16'h1FA0, 16'h0014);
  endtask

  task t_fill;
    for (m = 0; m < 6; m++) begin
      run_wait(m[2:0], m < 3 ? 16'h000A : 16'h0000, m < 3 ? 16'h0014 : 16'h0000, m < 3);
    end
    wr(16'h1F80, 16'h001E);
    run_wait(3'h0, 16'h001E, 16'h0014, 1'b1);
  endtask

  task t_ack;
    reply_pads = 8'h05;
    run_wait(3'h1, 16'h0005, 16'h0005, 1'b0);
    reply_pads = 8'h00;
    rd("delay stat p1", 16'h0818, 16'h0005);
    rd("delay stat p2", 16'h0838, 16'h0005);
  endtask

  task t_slave;
    P1_MODE = 3'h4;
    P1_MB_ADDR = 8'h11;
    frame(8'h22);
    chk("permit other address", 2'h0, {P1_TX_PERMIT, P2_TX_PERMIT});
    frame(8'h11);
    chk("permit own address", 2'h3, {P1_TX_PERMIT, P2_TX_PERMIT});
    P1_TX_DONE = 1'b1;
    step(1);
    P1_TX_DONE = 1'b0;
    step(1);
    chk("permit after reply", 2'h0, {P1_TX_PERMIT, P2_TX_PERMIT});
    P1_MODE = 3'h3;
    step(1);
    chk("master permit", 2'h3, {P1_TX_PERMIT, P2_TX_PERMIT});
    P1_MB_RTU = 1'b0;
    step(1);
    chk("ascii bits", 8'h77, {P1_DATA_BITS, P2_DATA_BITS});
    P1_MB_RTU = 1'b1;
    step(1);
    chk("rtu bits", 8'h88, {P1_DATA_BITS, P2_DATA_BITS});
  endtask

  task t_route;
    rt(4'h0, 64'h0, 2'h1, 6'h30);
    rt(4'h1, 64'h02, 2'h1, 6'h24);
    rt(4'h2, 64'h2C02, 2'h1, 6'h2A);
    rt(4'h3, 64'h2C0002, 2'h1, 6'h28);
    rt(4'h2, 64'h0200, 2'h0, 6'h29);
    rt(4'h2, 64'h0009, 2'h0, 6'h30);
    rt(4'h9, 64'h0, 2'h1, 6'h24);
    rt(4'h8, 64'h0002090909090909, 2'h1, 6'h28);
    rt(4'h2, 64'h4D02, 2'h1, 6'h24);
    P2_DROP = 8'h02;
    step(1);
    chk("drop conflict", 1, DROP_CONFLICT);
    rt(4'h2, 64'h0200, 2'h0, 6'h24, 6'h24);
    P2_DROP = 8'h2C;
  endtask

  initial begin
    CLK_SYS = 1'b0;
    SYS_RST = 1'b1;
    {REG_WR, REG_RD, P1_CKSUM_SENT, P1_RX_FRAME_END, P1_TX_DONE, RT_VALID} = 6'h00;
    {REG_NUM, REG_WDATA} = 32'h0;
    {P1_MODE, P1_MB_RTU, P1_MB_ADDR, P1_RX_FRAME_ADDR} = 20'h0;
    P1_BIT_CLKS = 16'h0002;
    P1_FRAME_BITS = 4'h3;
    {ETH_DROP, P1_DROP, P2_DROP} = 24'h00022C;
    {RT_LEN, RT_DROPS, RT_ARRIVE_PORT} = 70'h0;
    reply_pads = 8'h00;
    n_fail = 0;
    n_compared = 0;
    step(10);
    SYS_RST = 1'b0;
    step(1);
    t_regs();
    t_fill();
    t_ack();
    t_slave();
    t_route();
    wrap_up();
  end
endmodule
